// File: bench/bdm_map_asserts.sv
// Checker for the banked data memory map, bound to the top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module bdm_map_asserts (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  input wire logic       acc_flag_dest,
  input wire logic       rd_valid,
  input wire logic       alu_flag_valid,
  input wire logic       wdt_timeout,
  input wire logic       sleep_exec,
  input wire logic       clrwdt_exec,
  input wire logic       periph_valid,
  input wire logic       special_valid,
  input wire logic       periph_write,
  input wire logic [4:0] periph_bank,
  input wire logic [6:0] periph_offset,
  input wire logic [7:0] periph_wdata,
  input wire logic [7:0] status_out,
  input wire logic [4:0] bank_select_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Reads answer after exactly two cycles, and only reads answer
  read_answer_a: assert property (acc_valid && !acc_write |-> ##2 rd_valid)
    else $error("read answer missing");
  no_stray_answer_a: assert property (rd_valid |-> $past(acc_valid, 2) && !$past(acc_write, 2))
    else $error("answer without a read");
  // Peripheral offsets strobe the right set with the direct bank
  periph_strobe_a: assert property (acc_valid && acc_offset inside {[7'h0C:7'h1F]}
    && !(bank_select_out inside {[5'd27:5'd29]}) |=> periph_valid && !special_valid
    && periph_offset == $past(acc_offset) && periph_bank == $past(bank_select_out))
    else $error("peripheral strobe wrong");
  special_strobe_a: assert property (acc_valid && acc_offset inside {[7'h0C:7'h1F]}
    && bank_select_out inside {[5'd27:5'd29]} |=> special_valid && !periph_valid)
    else $error("special bank strobe wrong");
  periph_data_a: assert property (periph_valid |-> periph_write == $past(acc_write)
    && (!periph_write || periph_wdata == $past(acc_wdata)))
    else $error("peripheral write data wrong");
  bank_write_a: assert property (acc_valid && acc_write && acc_offset == 7'h08
    |=> {3'b000, bank_select_out} == ($past(acc_wdata) & 8'h1F))
    else $error("bank select not loaded");
  status_guard_a: assert property (acc_valid && acc_write && acc_offset == 7'h03
    && !wdt_timeout && !sleep_exec && !clrwdt_exec |=> $stable(status_out[4:3]))
    else $error("timeout or power-down written by bus");
  flag_suppress_a: assert property (acc_valid && acc_write && acc_offset == 7'h03
    && acc_flag_dest && !alu_flag_valid |=> $stable(status_out[2:0]))
    else $error("flag write not suppressed");
  timeout_clear_a: assert property (wdt_timeout |=> !status_out[4])
    else $error("timeout flag not cleared");
  status_unused_a: assert property (status_out[7:5] == 3'b000)
    else $error("unused status bits set");
endmodule
bind bdm_map bdm_map_asserts bdm_map_asserts_inst (.mclk(mclk), .reset_n(reset_n),
  .acc_valid(acc_valid), .acc_write(acc_write), .acc_offset(acc_offset), .acc_wdata(acc_wdata),
  .acc_flag_dest(acc_flag_dest), .rd_valid(rd_valid), .alu_flag_valid(alu_flag_valid),
  .wdt_timeout(wdt_timeout), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
  .periph_valid(periph_valid), .special_valid(special_valid), .periph_write(periph_write),
  .periph_bank(periph_bank), .periph_offset(periph_offset), .periph_wdata(periph_wdata),
  .status_out(status_out), .bank_select_out(bank_select_out));

// File: bench/bdm_map_tb.sv
// Self-checking bench for the banked data memory map, bank RAM cut to 64 bytes.
// Assumes the peripheral model answers in the strobe cycle.
`timescale 1ns/1ps
module bdm_map_tb;
  logic       mclk, reset_n, acc_valid, acc_write, acc_flag_dest, rd_valid, alu_flag_valid;
  logic       wdt_timeout, sleep_exec, clrwdt_exec, pc_low_load, periph_valid;
  logic       special_valid, periph_write;
  logic [6:0] acc_offset, periph_offset, pc_high_out;
  logic [7:0] acc_wdata, rd_data, periph_wdata, periph_rdata, special_rdata;
  logic [7:0] status_out, working_out, pc_low_out, intr_control_out;
  logic [4:0] periph_bank, bank_select_out;
  int         errors, compares, cyc;
  logic [7:0] rst_v [10] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] wr_v [10] = '{8'hA5, 8'h1D, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h05, 8'hA5, 8'h25, 8'h81};

  bdm_map #(.GPR_USED(64)) bdm_map_inst (.mclk(mclk), .reset_n(reset_n),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_offset(acc_offset),
    .acc_wdata(acc_wdata), .acc_flag_dest(acc_flag_dest), .rd_valid(rd_valid),
    .rd_data(rd_data), .alu_flag_valid(alu_flag_valid), .alu_zero(1'b0),
    .alu_digit_carry(1'b1), .alu_carry(1'b0), .wdt_timeout(wdt_timeout),
    .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec), .pc_low_load(pc_low_load),
    .pc_low_value(8'h3C), .periph_valid(periph_valid), .special_valid(special_valid),
    .periph_write(periph_write), .periph_bank(periph_bank), .periph_offset(periph_offset),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .special_rdata(special_rdata),
    .status_out(status_out), .bank_select_out(bank_select_out), .working_out(working_out),
    .pc_low_out(pc_low_out), .pc_high_out(pc_high_out), .intr_control_out(intr_control_out));
  bdm_periph_model bdm_periph_model_inst (.mclk(mclk), .periph_valid(periph_valid),
    .special_valid(special_valid), .periph_bank(periph_bank), .periph_offset(periph_offset),
    .periph_rdata(periph_rdata), .special_rdata(special_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard: the whole sequence needs under two hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write request, driven between edges
  task automatic wr(input logic [6:0] off, input logic [7:0] d, input logic fd = 1'b0);
    @(negedge mclk);
    acc_valid = 1'b1;
    acc_write = 1'b1;
    acc_offset = off;
    acc_wdata = d;
    acc_flag_dest = fd;
    @(negedge mclk);
    acc_valid = 1'b0;
    acc_flag_dest = 1'b0;
  endtask

  // Read request, then a bounded wait for the answer pulse
  task automatic rd(input logic [6:0] off, input logic [7:0] exp);
    int n;
    @(negedge mclk);
    acc_valid = 1'b1;
    acc_write = 1'b0;
    acc_offset = off;
    @(negedge mclk);
    acc_valid = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    chk(rd_valid === 1'b1 ? rd_data : ~exp, exp);
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  initial begin
    {acc_valid, acc_write, acc_flag_dest, alu_flag_valid} = 4'h0;
    {wdt_timeout, sleep_exec, clrwdt_exec, pc_low_load} = 4'h0;
    acc_offset = 7'h00;
    acc_wdata = 8'h00;
    reset_n = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    foreach (rst_v[i]) rd(7'(i + 2), rst_v[i]);
    foreach (wr_v[i]) begin
      wr(7'(i + 2), 8'hA5);
      rd(7'(i + 2), wr_v[i]);
    end
    chk(working_out, 8'hA5);
    chk(pc_low_out, 8'hA5);
    chk({1'b0, pc_high_out}, 8'h25);
    chk(intr_control_out, 8'h81);
    wr(7'h03, 8'h00, 1'b1);
    rd(7'h03, 8'h1D);
    pulse(sleep_exec);
    rd(7'h03, 8'h15);
    pulse(wdt_timeout);
    rd(7'h03, 8'h05);
    pulse(clrwdt_exec);
    pulse(alu_flag_valid);
    rd(7'h03, 8'h1A);
    pulse(pc_low_load);
    rd(7'h02, 8'h3C);
    // Bank RAM, its unimplemented tail, and common RAM across banks
    wr(7'h08, 8'h03);
    wr(7'h25, 8'h3C);
    wr(7'h08, 8'h04);
    wr(7'h25, 8'hC3);
    wr(7'h65, 8'h77);
    rd(7'h65, 8'h00);
    wr(7'h08, 8'h03);
    rd(7'h25, 8'h3C);
    wr(7'h08, 8'h00);
    wr(7'h70, 8'h5A);
    wr(7'h08, 8'h1F);
    rd(7'h70, 8'h5A);
    rd(7'h09, 8'hA5);
    // Pointer pairs: traditional, linear, and the unserved gap
    wr(7'h05, 8'h01);
    wr(7'h04, 8'hA5);
    rd(7'h00, 8'h3C);
    wr(7'h07, 8'h21);
    wr(7'h06, 8'h05);
    rd(7'h01, 8'hC3);
    wr(7'h01, 8'h99);
    wr(7'h08, 8'h04);
    rd(7'h25, 8'h99);
    wr(7'h05, 8'h10);
    rd(7'h00, 8'h00);
    // Peripheral sets, normal bank then a special bank
    wr(7'h08, 8'h02);
    rd(7'h0C, 8'h4C);
    rd(7'h1F, 8'h5F);
    wr(7'h0C, 8'h11);
    wr(7'h08, 8'h1C);
    rd(7'h1F, 8'h60);
    wr(7'h05, 8'h01);
    wr(7'h04, 8'h0C);
    rd(7'h00, 8'h4C);
    results();
  end
endmodule

// File: bench/bdm_periph_model.sv
// Behavioural peripheral and pin-select/logic-cell register sets.
// Assumes strobes and bank/offset come registered from the map on mclk.
`timescale 1ns/1ps
module bdm_periph_model (
  input  wire logic       mclk,
  input  wire logic       periph_valid,
  input  wire logic       special_valid,
  input  wire logic [4:0] periph_bank,
  input  wire logic [6:0] periph_offset,
  output logic      [7:0] periph_rdata,
  output logic      [7:0] special_rdata
);
  logic [7:0] churn_reg = 8'h00;
  // Changing pattern while unselected, so stale data never passes for an answer
  always_ff @(posedge mclk) begin
    churn_reg <= churn_reg + 8'h35;
  end
  // Each location answers with its bank low bits and offset, special sets inverted, in the strobe cycle
  assign periph_rdata  = periph_valid ? {periph_bank[2:0], periph_offset[4:0]} : churn_reg;
  assign special_rdata = special_valid ? ~{periph_bank[2:0], periph_offset[4:0]} : ~churn_reg;
endmodule

// File: common/bdm_pkg.sv
// Constants, region type and offset decoding for the banked data memory map.
// Assumes a 12-bit data address: five bank bits above a seven-bit bank offset.
package bdm_pkg;

  localparam int BANKS        = 32;
  localparam int GPR_MAX      = 80;
  localparam int COMMON_BYTES = 16;
  localparam int RAM_AW       = 12;

  // Core register offsets, identical in every bank
  localparam logic [6:0] OFF_PORT_ZERO    = 7'h00;
  localparam logic [6:0] OFF_PORT_ONE     = 7'h01;
  localparam logic [6:0] OFF_PC_LOW       = 7'h02;
  localparam logic [6:0] OFF_STATUS       = 7'h03;
  localparam logic [6:0] OFF_PTR0_LOW     = 7'h04;
  localparam logic [6:0] OFF_PTR0_HIGH    = 7'h05;
  localparam logic [6:0] OFF_PTR1_LOW     = 7'h06;
  localparam logic [6:0] OFF_PTR1_HIGH    = 7'h07;
  localparam logic [6:0] OFF_BANK_SELECT  = 7'h08;
  localparam logic [6:0] OFF_WORKING      = 7'h09;
  localparam logic [6:0] OFF_PC_HIGH      = 7'h0A;
  localparam logic [6:0] OFF_INTR_CONTROL = 7'h0B;
  localparam logic [6:0] OFF_PERIPH_LAST  = 7'h1F;
  localparam logic [6:0] OFF_GPR_FIRST    = 7'h20;
  localparam logic [6:0] OFF_GPR_LAST     = 7'h6F;
  localparam logic [6:0] OFF_COMMON_FIRST = 7'h70;

  localparam logic [4:0] BANK_SPECIAL_FIRST = 5'h1B;
  localparam logic [4:0] BANK_SPECIAL_LAST  = 5'h1D;

  // Pointer address space layout
  localparam logic [15:0] LIN_BASE       = 16'h2000;
  localparam logic [15:0] TRAD_LIMIT     = 16'h1000;
  localparam int          PROG_SPACE_BIT = 15;

  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_STATUS       = 8'h18;
  localparam logic [7:0] RST_INTR_CONTROL = 8'h01;
  localparam logic [7:0] MASK_STATUS      = 8'h1F;
  localparam logic [7:0] MASK_BANK        = 8'h1F;
  localparam logic [7:0] MASK_PC_HIGH     = 8'h7F;
  localparam logic [7:0] MASK_INTR        = 8'hC1;

  // Status bit positions
  localparam int ST_TIMEOUT   = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_ZERO      = 2;
  localparam int ST_DIGIT     = 1;
  localparam int ST_CARRY     = 0;

  typedef enum logic [2:0] {
    BDM_NONE,
    BDM_CORE,
    BDM_PERIPH,
    BDM_SPECIAL,
    BDM_GPR,
    BDM_COMMON
  } bdm_region_t;

  // Region of a bank offset, before RAM size limits are applied
  function automatic bdm_region_t region_of(input logic [4:0] bank, input logic [6:0] off);
    if (off <= OFF_INTR_CONTROL) begin
      region_of = BDM_CORE;
    end else if (off <= OFF_PERIPH_LAST) begin
      region_of = (bank >= BANK_SPECIAL_FIRST && bank <= BANK_SPECIAL_LAST)
                  ? BDM_SPECIAL : BDM_PERIPH;
    end else if (off <= OFF_GPR_LAST) begin
      region_of = BDM_GPR;
    end else begin
      region_of = BDM_COMMON;
    end
  endfunction

endpackage

// File: common/bdm_ram_if.sv
// Carrier between the map's decoder side and its RAM store.
// Assumes one access per clock, write or synchronous read.
`timescale 1ns/1ps
interface bdm_ram_if;
  logic                        wr_en;
  logic [bdm_pkg::RAM_AW-1:0]  index;
  logic [7:0]                  wdata;
  logic [7:0]                  rdata;

  modport client (output wr_en, output index, output wdata, input rdata);
  modport store  (input wr_en, input index, input wdata, output rdata);
endinterface

// File: core/bdm_decode.sv
// Resolves a direct or pointer-redirected access to region, bank, offset and RAM index.
// Assumes pointer values and bank select come from registers on the same clock.
`timescale 1ns/1ps
module bdm_decode #(
  parameter int GPR_USED = bdm_pkg::GPR_MAX
) (
  input  wire logic [6:0]                  acc_offset,
  input  wire logic [4:0]                  bank_sel,
  input  wire logic [15:0]                 ptr_zero,
  input  wire logic [15:0]                 ptr_one,
  output bdm_pkg::bdm_region_t             region,
  output logic [6:0]                       res_offset,
  output logic [bdm_pkg::RAM_AW-1:0]       ram_index
);
  localparam logic [15:0] LIN_END = bdm_pkg::LIN_BASE + 16'(bdm_pkg::BANKS * GPR_USED);
  localparam logic [bdm_pkg::RAM_AW-1:0] COMMON_BASE =
    bdm_pkg::RAM_AW'(bdm_pkg::BANKS * GPR_USED);

  if (GPR_USED < 1 || GPR_USED > bdm_pkg::GPR_MAX) begin : g_bad_size
    $error("bdm_decode: GPR_USED out of range");
  end

  logic [15:0] ptr;
  logic [4:0]  res_bank;
  logic        indirect;

  always_comb begin
    indirect   = (acc_offset == bdm_pkg::OFF_PORT_ZERO) ||
                 (acc_offset == bdm_pkg::OFF_PORT_ONE);
    ptr        = (acc_offset == bdm_pkg::OFF_PORT_ZERO) ? ptr_zero : ptr_one;
    res_bank   = bank_sel;
    res_offset = acc_offset;
    region     = bdm_pkg::region_of(bank_sel, acc_offset);
    ram_index  = '0;
    if (indirect) begin
      res_bank   = ptr[11:7];
      res_offset = ptr[6:0];
      region     = bdm_pkg::region_of(ptr[11:7], ptr[6:0]);
      // Program space and nested redirects are not served and read as zero
      if (ptr[bdm_pkg::PROG_SPACE_BIT]) begin
        region = bdm_pkg::BDM_NONE;
      end else if (ptr >= bdm_pkg::LIN_BASE && ptr < LIN_END) begin
        region    = bdm_pkg::BDM_GPR;
        ram_index = bdm_pkg::RAM_AW'(ptr - bdm_pkg::LIN_BASE);
      end else if (ptr >= bdm_pkg::TRAD_LIMIT ||
                   ptr[6:0] == bdm_pkg::OFF_PORT_ZERO || ptr[6:0] == bdm_pkg::OFF_PORT_ONE) begin
        region = bdm_pkg::BDM_NONE;
      end
    end
    // Bank RAM fills offsets upward from 0x20; beyond its size reads zero
    if (region == bdm_pkg::BDM_GPR && !(indirect && ptr >= bdm_pkg::LIN_BASE)) begin
      if (32'(res_offset - bdm_pkg::OFF_GPR_FIRST) >= GPR_USED) begin
        region = bdm_pkg::BDM_NONE;
      end else begin
        ram_index = bdm_pkg::RAM_AW'(res_bank) * bdm_pkg::RAM_AW'(GPR_USED)
                  + bdm_pkg::RAM_AW'(res_offset - bdm_pkg::OFF_GPR_FIRST);
      end
    end
    if (region == bdm_pkg::BDM_COMMON) begin
      ram_index = COMMON_BASE + bdm_pkg::RAM_AW'(res_offset - bdm_pkg::OFF_COMMON_FIRST);
    end
  end
endmodule

// File: core/bdm_map.sv
// Top of the banked data memory map: core registers, decode, RAM and peripheral routing.
// Assumes the processor issues at most one data access per clock on the same clock.
// Peripheral and special register sets answer with read data in the same cycle as their strobe.
`timescale 1ns/1ps
module bdm_map #(
  parameter int GPR_USED = bdm_pkg::GPR_MAX
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [6:0]  acc_offset,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        acc_flag_dest,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  input  wire logic        alu_flag_valid,
  input  wire logic        alu_zero,
  input  wire logic        alu_digit_carry,
  input  wire logic        alu_carry,
  input  wire logic        wdt_timeout,
  input  wire logic        sleep_exec,
  input  wire logic        clrwdt_exec,
  input  wire logic        pc_low_load,
  input  wire logic [7:0]  pc_low_value,
  output logic             periph_valid,
  output logic             special_valid,
  output logic             periph_write,
  output logic [4:0]       periph_bank,
  output logic [6:0]       periph_offset,
  output logic [7:0]       periph_wdata,
  input  wire logic [7:0]  periph_rdata,
  input  wire logic [7:0]  special_rdata,
  output logic [7:0]       status_out,
  output logic [4:0]       bank_select_out,
  output logic [7:0]       working_out,
  output logic [7:0]       pc_low_out,
  output logic [6:0]       pc_high_out,
  output logic [7:0]       intr_control_out
);
  localparam int RAM_DEPTH = bdm_pkg::BANKS * GPR_USED + bdm_pkg::COMMON_BYTES;

  // A bank RAM past eighty bytes would overlap common RAM
  if (GPR_USED < 1 || GPR_USED > bdm_pkg::GPR_MAX) begin : g_bad_gpr
    $error("bdm_map: GPR_USED out of range");
  end

  // Core register state
  logic [7:0] pc_low_reg,    pc_low_next;
  logic [7:0] status_reg,    status_next;
  logic [7:0] ptr0_low_reg,  ptr0_low_next;
  logic [7:0] ptr0_high_reg, ptr0_high_next;
  logic [7:0] ptr1_low_reg,  ptr1_low_next;
  logic [7:0] ptr1_high_reg, ptr1_high_next;
  logic [7:0] bank_reg,      bank_next;
  logic [7:0] working_reg,   working_next;
  logic [7:0] pc_high_reg,   pc_high_next;
  logic [7:0] intr_reg,      intr_next;

  // Access pipeline state
  logic                 s1_valid_reg,      s1_valid_next;
  bdm_pkg::bdm_region_t s1_region_reg,     s1_region_next;
  logic [7:0]           s1_core_reg,       s1_core_next;
  logic                 periph_valid_reg,  periph_valid_next;
  logic                 special_valid_reg, special_valid_next;
  logic                 periph_write_reg,  periph_write_next;
  logic [4:0]           periph_bank_reg,   periph_bank_next;
  logic [6:0]           periph_offset_reg, periph_offset_next;
  logic [7:0]           periph_wdata_reg,  periph_wdata_next;
  logic                 rd_valid_reg,      rd_valid_next;
  logic [7:0]           rd_data_reg,       rd_data_next;

  // Decode results for the access in flight
  bdm_pkg::bdm_region_t        region;
  logic [6:0]                  res_offset;
  logic [bdm_pkg::RAM_AW-1:0]  ram_index;
  logic [7:0]                  core_rd;
  logic                        core_wr;

  // Carrier between map and RAM store
  bdm_ram_if ram_bus ();

  bdm_decode #(
    .GPR_USED (GPR_USED)
  ) u_decode (
    .acc_offset (acc_offset),
    .bank_sel   (bank_reg[4:0]),
    .ptr_zero   ({ptr0_high_reg, ptr0_low_reg}),
    .ptr_one    ({ptr1_high_reg, ptr1_low_reg}),
    .region     (region),
    .res_offset (res_offset),
    .ram_index  (ram_index)
  );

  bdm_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .mclk (mclk),
    .ram  (ram_bus.store)
  );

  // Only bank RAM and common RAM regions reach the store
  assign ram_bus.index = ram_index;
  assign ram_bus.wdata = acc_wdata;
  assign ram_bus.wr_en = acc_valid && acc_write &&
                         (region == bdm_pkg::BDM_GPR || region == bdm_pkg::BDM_COMMON);

  // Core writes follow the resolved region, redirects included
  assign core_wr = acc_valid && acc_write && (region == bdm_pkg::BDM_CORE);

  // Core read mux; the redirect offsets never land here, they resolve elsewhere
  always_comb begin
    core_rd = bdm_pkg::RST_ZERO;
    case (res_offset)
      bdm_pkg::OFF_PC_LOW:       core_rd = pc_low_reg;
      bdm_pkg::OFF_STATUS:       core_rd = status_reg & bdm_pkg::MASK_STATUS;
      bdm_pkg::OFF_PTR0_LOW:     core_rd = ptr0_low_reg;
      bdm_pkg::OFF_PTR0_HIGH:    core_rd = ptr0_high_reg;
      bdm_pkg::OFF_PTR1_LOW:     core_rd = ptr1_low_reg;
      bdm_pkg::OFF_PTR1_HIGH:    core_rd = ptr1_high_reg;
      bdm_pkg::OFF_BANK_SELECT:  core_rd = bank_reg & bdm_pkg::MASK_BANK;
      bdm_pkg::OFF_WORKING:      core_rd = working_reg;
      bdm_pkg::OFF_PC_HIGH:      core_rd = pc_high_reg & bdm_pkg::MASK_PC_HIGH;
      bdm_pkg::OFF_INTR_CONTROL: core_rd = intr_reg & bdm_pkg::MASK_INTR;
      default:                   core_rd = bdm_pkg::RST_ZERO;
    endcase
  end

  // Core register writes; a bus write to the PC low byte overrides the sequencer load
  always_comb begin
    pc_low_next    = pc_low_reg;
    ptr0_low_next  = ptr0_low_reg;
    ptr0_high_next = ptr0_high_reg;
    ptr1_low_next  = ptr1_low_reg;
    ptr1_high_next = ptr1_high_reg;
    bank_next      = bank_reg;
    working_next   = working_reg;
    pc_high_next   = pc_high_reg;
    intr_next      = intr_reg;

    if (pc_low_load) begin
      pc_low_next = pc_low_value;
    end

    if (core_wr) begin
      case (res_offset)
        bdm_pkg::OFF_PC_LOW:       pc_low_next    = acc_wdata;
        bdm_pkg::OFF_PTR0_LOW:     ptr0_low_next  = acc_wdata;
        bdm_pkg::OFF_PTR0_HIGH:    ptr0_high_next = acc_wdata;
        bdm_pkg::OFF_PTR1_LOW:     ptr1_low_next  = acc_wdata;
        bdm_pkg::OFF_PTR1_HIGH:    ptr1_high_next = acc_wdata;
        bdm_pkg::OFF_BANK_SELECT:  bank_next      = acc_wdata & bdm_pkg::MASK_BANK;
        bdm_pkg::OFF_WORKING:      working_next   = acc_wdata;
        bdm_pkg::OFF_PC_HIGH:      pc_high_next   = acc_wdata & bdm_pkg::MASK_PC_HIGH;
        bdm_pkg::OFF_INTR_CONTROL: intr_next      = acc_wdata & bdm_pkg::MASK_INTR;
        default:                   working_next   = working_reg;
      endcase
    end
  end

  // Status: ALU flag updates win over a same-cycle software write
  always_comb begin
    status_next = status_reg;
    if (core_wr && res_offset == bdm_pkg::OFF_STATUS && !acc_flag_dest) begin
      status_next[bdm_pkg::ST_ZERO]  = acc_wdata[bdm_pkg::ST_ZERO];
      status_next[bdm_pkg::ST_DIGIT] = acc_wdata[bdm_pkg::ST_DIGIT];
      status_next[bdm_pkg::ST_CARRY] = acc_wdata[bdm_pkg::ST_CARRY];
    end

    if (alu_flag_valid) begin
      status_next[bdm_pkg::ST_ZERO]  = alu_zero;
      status_next[bdm_pkg::ST_DIGIT] = alu_digit_carry;
      status_next[bdm_pkg::ST_CARRY] = alu_carry;
    end

    // Timeout and power-down move only on core events, never on writes
    if (clrwdt_exec) begin
      status_next[bdm_pkg::ST_TIMEOUT]   = 1'b1;
      status_next[bdm_pkg::ST_POWERDOWN] = 1'b1;
    end
    if (sleep_exec) begin
      status_next[bdm_pkg::ST_TIMEOUT]   = 1'b1;
      status_next[bdm_pkg::ST_POWERDOWN] = 1'b0;
    end
    if (wdt_timeout) begin
      status_next[bdm_pkg::ST_TIMEOUT] = 1'b0;
    end

    status_next = status_next & bdm_pkg::MASK_STATUS;
  end

  // Core register set; loaded on power-on and brown-out reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_low_reg    <= bdm_pkg::RST_ZERO;
      status_reg    <= bdm_pkg::RST_STATUS;
      ptr0_low_reg  <= bdm_pkg::RST_ZERO;
      ptr0_high_reg <= bdm_pkg::RST_ZERO;
      ptr1_low_reg  <= bdm_pkg::RST_ZERO;
      ptr1_high_reg <= bdm_pkg::RST_ZERO;
      bank_reg      <= bdm_pkg::RST_ZERO;
      working_reg   <= bdm_pkg::RST_ZERO;
      pc_high_reg   <= bdm_pkg::RST_ZERO;
      intr_reg      <= bdm_pkg::RST_INTR_CONTROL;
    end else begin
      pc_low_reg    <= pc_low_next;
      status_reg    <= status_next;
      ptr0_low_reg  <= ptr0_low_next;
      ptr0_high_reg <= ptr0_high_next;
      ptr1_low_reg  <= ptr1_low_next;
      ptr1_high_reg <= ptr1_high_next;
      bank_reg      <= bank_next;
      working_reg   <= working_next;
      pc_high_reg   <= pc_high_next;
      intr_reg      <= intr_next;
    end
  end

  // Stage one launches peripheral strobes; every read answers two cycles after request
  always_comb begin
    s1_valid_next      = acc_valid && !acc_write;
    s1_region_next     = region;
    s1_core_next       = core_rd;
    periph_valid_next  = acc_valid && (region == bdm_pkg::BDM_PERIPH);
    special_valid_next = acc_valid && (region == bdm_pkg::BDM_SPECIAL);
    periph_write_next  = acc_write;
    periph_bank_next   = periph_bank_reg;
    periph_offset_next = periph_offset_reg;
    periph_wdata_next  = periph_wdata_reg;

    if (periph_valid_next || special_valid_next) begin
      // Pointer bank is address bits 11:7, across both pointer bytes
      periph_bank_next   = bank_reg[4:0];
      if (acc_offset == bdm_pkg::OFF_PORT_ZERO) begin
        periph_bank_next = {ptr0_high_reg[3:0], ptr0_low_reg[7]};
      end else if (acc_offset == bdm_pkg::OFF_PORT_ONE) begin
        periph_bank_next = {ptr1_high_reg[3:0], ptr1_low_reg[7]};
      end
      periph_offset_next = res_offset;
      periph_wdata_next  = acc_wdata;
    end

    // Stage two picks the answer by the region latched at request
    rd_valid_next = s1_valid_reg;
    rd_data_next  = rd_data_reg;
    if (s1_valid_reg) begin
      case (s1_region_reg)
        bdm_pkg::BDM_CORE:    rd_data_next = s1_core_reg;
        bdm_pkg::BDM_GPR:     rd_data_next = ram_bus.rdata;
        bdm_pkg::BDM_COMMON:  rd_data_next = ram_bus.rdata;
        bdm_pkg::BDM_PERIPH:  rd_data_next = periph_rdata;
        bdm_pkg::BDM_SPECIAL: rd_data_next = special_rdata;
        default:              rd_data_next = bdm_pkg::RST_ZERO;
      endcase
    end
  end

  // Pipeline registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_valid_reg      <= 1'b0;
      s1_region_reg     <= bdm_pkg::BDM_NONE;
      s1_core_reg       <= bdm_pkg::RST_ZERO;
      periph_valid_reg  <= 1'b0;
      special_valid_reg <= 1'b0;
      periph_write_reg  <= 1'b0;
      periph_bank_reg   <= '0;
      periph_offset_reg <= '0;
      periph_wdata_reg  <= bdm_pkg::RST_ZERO;
      rd_valid_reg      <= 1'b0;
      rd_data_reg       <= bdm_pkg::RST_ZERO;
    end else begin
      s1_valid_reg      <= s1_valid_next;
      s1_region_reg     <= s1_region_next;
      s1_core_reg       <= s1_core_next;
      periph_valid_reg  <= periph_valid_next;
      special_valid_reg <= special_valid_next;
      periph_write_reg  <= periph_write_next;
      periph_bank_reg   <= periph_bank_next;
      periph_offset_reg <= periph_offset_next;
      periph_wdata_reg  <= periph_wdata_next;
      rd_valid_reg      <= rd_valid_next;
      rd_data_reg       <= rd_data_next;
    end
  end

  // Outputs straight from flops
  assign rd_valid         = rd_valid_reg;
  assign rd_data          = rd_data_reg;
  assign periph_valid     = periph_valid_reg;
  assign special_valid    = special_valid_reg;
  assign periph_write     = periph_write_reg;
  assign periph_bank      = periph_bank_reg;
  assign periph_offset    = periph_offset_reg;
  assign periph_wdata     = periph_wdata_reg;

  // Core register views
  assign status_out       = status_reg;
  assign bank_select_out  = bank_reg[4:0];
  assign working_out      = working_reg;
  assign pc_low_out       = pc_low_reg;
  assign pc_high_out      = pc_high_reg[6:0];
  assign intr_control_out = intr_reg;
endmodule

// File: core/bdm_ram.sv
// Bank RAM and common RAM storage, one flat array.
// Assumes the client has already folded bank and offset into an index.
`timescale 1ns/1ps
module bdm_ram #(
  parameter int DEPTH = 2576
) (
  input wire logic   mclk,
  bdm_ram_if.store   ram
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Out-of-range index reads zero instead of indexing past the array
  always_comb begin
    rdata_next = bdm_pkg::RST_ZERO;
    if (32'(ram.index) < DEPTH) begin
      rdata_next = mem[ram.index];
    end
  end

  // Storage holds no reset; contents are undefined after power-up
  always_ff @(posedge mclk) begin
    if (ram.wr_en && 32'(ram.index) < DEPTH) begin
      mem[ram.index] <= ram.wdata;
    end
    rdata_reg <= rdata_next;
  end

  assign ram.rdata = rdata_reg;
endmodule
